// ---- mhs_defines.svh ----
// Shared constants for the meter host serial port ends.
`ifndef MHS_DEFINES_SVH
`define MHS_DEFINES_SVH
// Serial frame layout: 8-bit command byte then one data byte.
`define MHS_CMD_BITS 4'h8
`define MHS_DATA_BITS 4'h8
`define MHS_FRAME_BITS 5'h10
// Bit 7 of the command byte marks a write; low 7 bits address a register.
`define MHS_CMD_WRITE_BIT 7
// Register addresses inside the device.
`define MHS_ADDR_WAVEMODE 7'h01
`define MHS_ADDR_NUM 7'h02
`define MHS_ADDR_DEN 7'h03
`define MHS_ADDR_IRQ_MASK 7'h04
`define MHS_ADDR_IRQ_STATUS 7'h05
`define MHS_ADDR_FILTER 7'h06
// Field positions.
`define MHS_WAVE_VA_SEL_BIT 7
`define MHS_IRQ_ACT_HALF_BIT 0
`define MHS_IRQ_APP_HALF_BIT 1
`define MHS_IRQ_WAVE_BIT 2
`define MHS_FILTER_EN_BIT 0
// Reset values.
`define MHS_RESET_NUM 8'h00
`define MHS_RESET_DEN 8'h00
`define MHS_RESET_MASK 8'h00
`define MHS_RESET_WAVE 8'h00
`define MHS_RESET_FILTER 8'h01
// Master clock in kHz and sample rate in samples per second.
`define MHS_CLK_KHZ 125000
`define MHS_WAVE_SPS 26000
// Cycles between waveform samples, rounded down (shortest interval).
`define MHS_WAVE_CYCLES ((`MHS_CLK_KHZ * 1000) / `MHS_WAVE_SPS)
// Host serial clock half period in master clocks.
`define MHS_HOST_HALF 10
`endif

// ---- mhs_pkg.sv ----
// Types shared by the meter host serial port ends.
package mhs_pkg;
   // Host transfer sequencer states.
   typedef enum logic [1:0] {
      MHS_IDLE = 2'b00,
      MHS_LOW = 2'b01,
      MHS_HIGH = 2'b10,
      MHS_DONE = 2'b11
   } mhs_state_t;
endpackage

// ---- mhs_link_if.sv ----
// Pin-level link between the meter device and its host.
`timescale 1ns/1ps
interface mhs_link_if;
   logic select_n; // Active-low select from host.
   logic sclk; // Serial clock from host.
   logic din; // Host to device data.
   logic dout_o; // Device data out value.
   logic dout_oe; // Device drives data out while high.
   logic irq_n_o; // Device interrupt output value (always low).
   logic irq_n_oe; // Device pulls interrupt low while high.
   // Resolved wire levels; interrupt line has a pull-up.
   wire dout_bus = dout_oe ? dout_o : 1'b1;
   wire irq_n_bus = irq_n_oe ? irq_n_o : 1'b1;
   modport device (input select_n, input sclk, input din, output dout_o, output dout_oe,
      output irq_n_o, output irq_n_oe);
   modport host (output select_n, output sclk, output din, input dout_bus, input irq_n_bus);
endinterface

// ---- mhs_device.sv ----
// Meter device end: serial slave, control registers, interrupt and frequency output.
//
// Operation
// - Cal output carries reactive or apparent power.
// - Numerator and denominator scale cal output frequency.
// - Interrupt line only pulled low, open drain.
// - Maskable interrupts: active, apparent half, waveform.
// - Host supplies the master clock externally.
// - Device transfers only while selected.
// - Input data captured on serial clock fall.
// - Output data launched on serial clock rise.
// - Data out undriven except during read data.
// - Serial bits move only on serial clock.
// - Enabled high-pass filter removes current offset.
`timescale 1ns/1ps
`include "mhs_defines.svh"
module mhs_device #(
   parameter int SAMPLE_W = 16,
   parameter int WAVE_CYCLES = `MHS_WAVE_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   mhs_link_if.device link,
   input wire logic signed [SAMPLE_W-1:0] current_sample,
   input wire logic [SAMPLE_W-1:0] reactive_power,
   input wire logic [SAMPLE_W-1:0] apparent_power,
   input wire logic active_half_event,
   input wire logic apparent_half_event,
   output logic reactive_cal_freq_out,
   output logic signed [SAMPLE_W-1:0] filtered_current
);
   // Two-stage synchronisers for the host pins.
   logic [1:0] cs_sync_reg;
   logic [1:0] sclk_sync_reg;
   logic [1:0] din_sync_reg;
   logic sclk_last_reg; // Previous synchronised serial clock.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cs_sync_reg <= 2'h3;
         // Serial clock idles high, so reset to that level to avoid a false rise.
         sclk_sync_reg <= 2'h3;
         din_sync_reg <= 2'h0;
         sclk_last_reg <= 1'b1;
      end else begin
         cs_sync_reg <= {cs_sync_reg[0], link.select_n};
         sclk_sync_reg <= {sclk_sync_reg[0], link.sclk};
         din_sync_reg <= {din_sync_reg[0], link.din};
         sclk_last_reg <= sclk_sync_reg[1];
      end
   end
   // Edge decode is gated by select; apart from the deselect abort, nothing moves without a serial clock edge.
   wire selected = ~cs_sync_reg[1];
   wire sclk_fall = selected & sclk_last_reg & ~sclk_sync_reg[1];
   wire sclk_rise = selected & ~sclk_last_reg & sclk_sync_reg[1];

   // Frame state.
   logic [4:0] bit_cnt_reg; // Bits captured so far in the frame.
   logic [7:0] cmd_reg; // Captured command byte.
   logic [7:0] shift_in_reg; // Incoming data shifter.
   logic [7:0] shift_out_reg; // Outgoing read data shifter.
   logic dout_reg; // Current data out value.
   logic dout_en_reg; // Data out enable.
   logic [7:0] wave_mode_reg; // Waveform mode register.
   logic [7:0] num_reg; // Frequency numerator.
   logic [7:0] den_reg; // Frequency denominator.
   logic [7:0] mask_reg; // Interrupt mask.
   logic [7:0] status_reg; // Sticky interrupt status.
   logic [7:0] filter_reg; // Filter enable register.
   logic wave_tick_reg; // Waveform sample available pulse.

   // Decoded command fields and the byte that completes at this fall.
   wire cmd_done = sclk_fall & (bit_cnt_reg == {1'b0, `MHS_CMD_BITS} - 5'h1);
   wire data_done = sclk_fall & (bit_cnt_reg == `MHS_FRAME_BITS - 5'h1);
   wire [7:0] in_byte = {shift_in_reg[6:0], din_sync_reg[1]};
   wire is_write = cmd_reg[`MHS_CMD_WRITE_BIT];
   wire [6:0] addr = cmd_reg[6:0];
   wire wr_en = data_done & is_write;
   wire rd_clear = data_done & ~is_write & (addr == `MHS_ADDR_IRQ_STATUS);
   // Read multiplexer for the addressed register.
   wire [7:0] rd_data =
      (in_byte[6:0] == `MHS_ADDR_WAVEMODE) ? wave_mode_reg :
      (in_byte[6:0] == `MHS_ADDR_NUM) ? num_reg :
      (in_byte[6:0] == `MHS_ADDR_DEN) ? den_reg :
      (in_byte[6:0] == `MHS_ADDR_IRQ_MASK) ? mask_reg :
      (in_byte[6:0] == `MHS_ADDR_IRQ_STATUS) ? status_reg :
      (in_byte[6:0] == `MHS_ADDR_FILTER) ? filter_reg : 8'h00;

   // Serial shifter: capture on fall, launch on rise, abort when deselected.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bit_cnt_reg <= 5'h00;
         cmd_reg <= 8'h00;
         shift_in_reg <= 8'h00;
         shift_out_reg <= 8'h00;
         dout_reg <= 1'b0;
         dout_en_reg <= 1'b0;
      end else if (!selected) begin
         bit_cnt_reg <= 5'h00;
         dout_en_reg <= 1'b0;
      end else begin
         if (sclk_fall) begin
            shift_in_reg <= in_byte;
            bit_cnt_reg <= data_done ? 5'h00 : bit_cnt_reg + 5'h01;
            if (cmd_done) begin
               cmd_reg <= in_byte;
               shift_out_reg <= rd_data;
            end
            if (data_done) begin
               dout_en_reg <= 1'b0;
            end
         end
         if (sclk_rise && bit_cnt_reg >= {1'b0, `MHS_CMD_BITS} && !is_write) begin
            dout_reg <= shift_out_reg[7];
            shift_out_reg <= {shift_out_reg[6:0], 1'b0};
            dout_en_reg <= 1'b1;
         end
      end
   end
   assign link.dout_o = dout_reg;
   assign link.dout_oe = dout_en_reg;

   // Control registers written by the host.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wave_mode_reg <= `MHS_RESET_WAVE;
         num_reg <= `MHS_RESET_NUM;
         den_reg <= `MHS_RESET_DEN;
         mask_reg <= `MHS_RESET_MASK;
         filter_reg <= `MHS_RESET_FILTER;
      end else if (wr_en) begin
         if (addr == `MHS_ADDR_WAVEMODE) wave_mode_reg <= in_byte;
         if (addr == `MHS_ADDR_NUM) num_reg <= in_byte;
         if (addr == `MHS_ADDR_DEN) den_reg <= in_byte;
         if (addr == `MHS_ADDR_IRQ_MASK) mask_reg <= in_byte;
         if (addr == `MHS_ADDR_FILTER) filter_reg <= in_byte;
      end
   end

   // Waveform sample tick at the sample rate.
   logic [$clog2(WAVE_CYCLES+1)-1:0] wave_cnt_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wave_cnt_reg <= '0;
         wave_tick_reg <= 1'b0;
      end else begin
         wave_tick_reg <= (wave_cnt_reg == '0);
         wave_cnt_reg <= (wave_cnt_reg == '0) ? ($clog2(WAVE_CYCLES+1))'(WAVE_CYCLES - 1) : wave_cnt_reg - 1'b1;
      end
   end

   // Sticky interrupt status; a new event wins over a read clear.
   wire [7:0] events = {5'h00, wave_tick_reg, apparent_half_event, active_half_event};
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status_reg <= 8'h00;
      end else begin
         status_reg <= (rd_clear ? 8'h00 : status_reg) | events;
      end
   end
   // Open-drain interrupt: value fixed low, only the enable moves.
   logic irq_oe_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_oe_reg <= 1'b0;
      end else begin
         irq_oe_reg <= |(status_reg & mask_reg);
      end
   end
   assign link.irq_n_o = 1'b0;
   assign link.irq_n_oe = irq_oe_reg;

   // Calibration frequency: pick power, accumulate scaled by (num+1)/(den+1).
   wire [SAMPLE_W-1:0] cal_power = wave_mode_reg[`MHS_WAVE_VA_SEL_BIT] ? apparent_power : reactive_power;
   wire [SAMPLE_W+7:0] cal_step = cal_power * ({1'b0, num_reg} + 9'h001);
   // Limit is (den+1) shifted up by SAMPLE_W+8; one extra bit keeps the largest denominator from wrapping to zero.
   wire [SAMPLE_W+16:0] cal_limit = {({1'b0, den_reg} + 9'h001), {(SAMPLE_W+8){1'b0}}};
   logic [SAMPLE_W+16:0] cal_acc_reg;
   wire [SAMPLE_W+16:0] cal_sum = cal_acc_reg + {9'h000, cal_step};
   wire cal_wrap = (cal_sum >= cal_limit);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cal_acc_reg <= '0;
         reactive_cal_freq_out <= 1'b0;
      end else begin
         cal_acc_reg <= cal_wrap ? cal_sum - cal_limit : cal_sum;
         if (cal_wrap) reactive_cal_freq_out <= ~reactive_cal_freq_out;
      end
   end

   // High-pass filter: subtract a slowly tracking offset estimate.
   logic signed [SAMPLE_W+7:0] offset_reg;
   wire signed [SAMPLE_W-1:0] offset_est = offset_reg[SAMPLE_W+7:8];
   wire signed [SAMPLE_W-1:0] hp_out = current_sample - offset_est;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         offset_reg <= '0;
         filtered_current <= '0;
      end else if (filter_reg[`MHS_FILTER_EN_BIT]) begin
         offset_reg <= offset_reg + (SAMPLE_W+8)'(hp_out);
         filtered_current <= hp_out;
      end else begin
         offset_reg <= '0;
         filtered_current <= current_sample;
      end
   end
endmodule

// ---- mhs_host.sv ----
// Host end: drives select, serial clock and data for one 16-bit frame per request.
`timescale 1ns/1ps
`include "mhs_defines.svh"
module mhs_host (
   input wire logic clk,
   input wire logic reset,
   mhs_link_if.host link,
   input wire logic req,
   input wire logic [7:0] req_cmd,
   input wire logic [7:0] req_wdata,
   output logic busy,
   output logic done,
   output logic [7:0] rdata,
   output logic irq_pending
);
   mhs_pkg::mhs_state_t state_reg;
   logic [3:0] div_reg; // Half-period counter for the serial clock.
   logic [4:0] bit_reg; // Bits sent in the frame.
   logic [15:0] tx_reg; // Outgoing frame, MSB first.
   logic [7:0] rx_reg; // Read data collected.
   logic cs_n_reg;
   logic sclk_reg;
   logic [1:0] dout_sync_reg; // Synchroniser for device data out.
   logic [1:0] irq_sync_reg; // Synchroniser for interrupt line.
   wire half_done = (div_reg == 4'(`MHS_HOST_HALF - 1));

   // Pin synchronisers.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dout_sync_reg <= 2'h0;
         irq_sync_reg <= 2'h3;
         irq_pending <= 1'b0;
      end else begin
         dout_sync_reg <= {dout_sync_reg[0], link.dout_bus};
         irq_sync_reg <= {irq_sync_reg[0], link.irq_n_bus};
         irq_pending <= ~irq_sync_reg[1];
      end
   end

   // Frame sequencer: clock idles high, data changes on rise, device samples on fall.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= mhs_pkg::MHS_IDLE;
         div_reg <= 4'h0;
         bit_reg <= 5'h00;
         tx_reg <= 16'h0000;
         rx_reg <= 8'h00;
         cs_n_reg <= 1'b1;
         sclk_reg <= 1'b1;
         busy <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
      end else begin
         done <= 1'b0;
         div_reg <= half_done ? 4'h0 : div_reg + 4'h1;
         case (state_reg)
            mhs_pkg::MHS_IDLE: begin
               div_reg <= 4'h0;
               if (req) begin
                  tx_reg <= {req_cmd, req_wdata};
                  cs_n_reg <= 1'b0;
                  busy <= 1'b1;
                  bit_reg <= 5'h00;
                  state_reg <= mhs_pkg::MHS_HIGH;
               end
            end
            mhs_pkg::MHS_HIGH: begin
               if (half_done) begin
                  sclk_reg <= 1'b0;
                  // Read data is taken at the fall, half a period after the device launched it on the rise.
                  if (bit_reg >= {1'b0, `MHS_CMD_BITS}) rx_reg <= {rx_reg[6:0], dout_sync_reg[1]};
                  state_reg <= mhs_pkg::MHS_LOW;
               end
            end
            mhs_pkg::MHS_LOW: begin
               if (half_done) begin
                  sclk_reg <= 1'b1;
                  tx_reg <= {tx_reg[14:0], 1'b0};
                  bit_reg <= bit_reg + 5'h01;
                  state_reg <= (bit_reg == `MHS_FRAME_BITS - 5'h1) ? mhs_pkg::MHS_DONE : mhs_pkg::MHS_HIGH;
               end
            end
            mhs_pkg::MHS_DONE: begin
               if (half_done) begin
                  cs_n_reg <= 1'b1;
                  busy <= 1'b0;
                  done <= 1'b1;
                  rdata <= rx_reg;
                  state_reg <= mhs_pkg::MHS_IDLE;
               end
            end
            default: state_reg <= mhs_pkg::MHS_IDLE;
         endcase
      end
   end
   assign link.select_n = cs_n_reg;
   assign link.sclk = sclk_reg;
   assign link.din = tx_reg[15];
endmodule

// ---- mhs_link_checker.sv ----
// Concurrent checks on the serial link wires between host and device.
`timescale 1ns/1ps
module mhs_link_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic select_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic dout_o,
   input wire logic dout_oe,
   input wire logic irq_n_o,
   input wire logic irq_n_oe
);
   logic sclk_q; // Serial clock level one cycle back.
   logic [3:0] rise_age; // Cycles since the last serial clock rise, saturating.
   // Ages each serial clock rise so output moves can be tied to one.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sclk_q <= 1'b1;
         rise_age <= 4'hF;
      end else begin
         sclk_q <= sclk;
         rise_age <= (sclk && !sclk_q) ? 4'h0 : ((rise_age == 4'hF) ? rise_age : rise_age + 4'h1);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // A falling serial clock, and the low phase that must follow it.
   sequence sclk_fall_s; $fell(sclk); endsequence
   sequence sclk_low_s; (!sclk) [*8]; endsequence
   irq_drain_only_a: assert property (irq_n_oe |-> !irq_n_o) else $error("interrupt line driven high");
   dout_idle_a: assert property (select_n [*6] |-> !dout_oe) else $error("data out driven while idle");
   dout_drop_a: assert property ($rose(select_n) |-> ##[0:4] !dout_oe) else $error("data out kept");
   dout_launch_a: assert property ((dout_oe && $past(dout_oe) && $changed(dout_o)) |->
      (rise_age >= 4'h1 && rise_age <= 4'h6)) else $error("data out moved off a clock rise");
   oe_on_rise_a: assert property ($rose(dout_oe) |-> (!select_n && rise_age >= 4'h1 && rise_age <= 4'h6))
      else $error("data out enabled off a clock rise");
   din_hold_a: assert property (sclk_fall_s |-> $stable(din) ##1 $stable(din) [*3])
      else $error("data in moved at clock fall");
   sclk_low_a: assert property (sclk_fall_s |=> sclk_low_s ##2 sclk) else $error("clock low phase wrong");
   sclk_quiet_a: assert property (select_n |-> sclk) else $error("clock moved while deselected");
   frame_len_a: assert property ($fell(select_n) |-> ##[325:335] $rose(select_n))
      else $error("frame length wrong");
endmodule

// ---- meter_host_serial_port_pins_tb.sv ----
// Bench joining host and device ends, driving frames and checking results.
`timescale 1ns/1ps
`include "mhs_defines.svh"
module meter_host_serial_port_pins_tb;
   localparam int WAVE_CYC = 50; // Short waveform tick keeps the run brief.
   logic clk, reset, req, busy, done, irq_pending, active_half_event, apparent_half_event, reactive_cal_freq_out;
   logic [7:0] req_cmd, req_wdata, rdata, rd;
   logic signed [15:0] current_sample, filtered_current;
   logic [15:0] reactive_power, apparent_power;
   int error_cnt, tests_run, n;
   // Register addresses, their reset values and write patterns (last two unmapped).
   logic [6:0] addr_tab [7] = '{`MHS_ADDR_WAVEMODE, `MHS_ADDR_NUM, `MHS_ADDR_DEN, `MHS_ADDR_IRQ_MASK,
      `MHS_ADDR_FILTER, 7'h00, 7'h7F};
   logic [7:0] rst_tab [7] = '{`MHS_RESET_WAVE, `MHS_RESET_NUM, `MHS_RESET_DEN, `MHS_RESET_MASK,
      `MHS_RESET_FILTER, 8'h00, 8'h00};
   logic [7:0] pat_tab [5] = '{8'h80, 8'h1E, 8'hB4, 8'h07, 8'h00};
   mhs_link_if link();
   mhs_host u_mhs_host (.clk(clk), .reset(reset), .link(link), .req(req), .req_cmd(req_cmd),
      .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata), .irq_pending(irq_pending));
   mhs_device #(.SAMPLE_W(16), .WAVE_CYCLES(WAVE_CYC)) u_mhs_device (.clk(clk), .reset(reset), .link(link),
      .current_sample(current_sample), .reactive_power(reactive_power), .apparent_power(apparent_power),
      .active_half_event(active_half_event), .apparent_half_event(apparent_half_event),
      .reactive_cal_freq_out(reactive_cal_freq_out), .filtered_current(filtered_current));
   mhs_link_checker u_mhs_link_checker (.clk(clk), .reset(reset), .select_n(link.select_n), .sclk(link.sclk),
      .din(link.din), .dout_o(link.dout_o), .dout_oe(link.dout_oe), .irq_n_o(link.irq_n_o),
      .irq_n_oe(link.irq_n_oe));
   // Free-running master clock.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Compares one value and counts it.
   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask
   // Runs one host frame and waits a bounded time for its completion pulse.
   task xfer(input logic [7:0] cmd, input logic [7:0] wd);
      int k;
      @(posedge clk);
      #1 req = 1'b1;
      req_cmd = cmd;
      req_wdata = wd;
      @(posedge clk);
      #1 req = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 400) begin
         @(posedge clk);
         #1 k++;
      end
      chk({15'h0000, k < 400}, 16'h0001);
      rd = rdata;
   endtask
   // Raises one accumulator half-level event for a single cycle.
   task pulse(input int which);
      @(posedge clk);
      #1 active_half_event = (which == 0);
      apparent_half_event = (which == 1);
      @(posedge clk);
      #1 active_half_event = 1'b0;
      apparent_half_event = 1'b0;
   endtask
   // Counts calibration output toggles over 200 cycles.
   task count_toggles;
      logic last;
      n = 0;
      last = reactive_cal_freq_out;
      repeat (200) begin
         @(posedge clk);
         #1 if (reactive_cal_freq_out !== last) n++;
         last = reactive_cal_freq_out;
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task end_sim;
      $display("errors=%0d checks=%0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Cuts a hung run short.
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
   // Main sequence of frames and checks.
   initial begin
      reset = 1'b1;
      {req, req_cmd, req_wdata, active_half_event, apparent_half_event} = '0;
      current_sample = 16'sh0000;
      reactive_power = 16'h0000;
      apparent_power = 16'h0000;
      error_cnt = 0;
      tests_run = 0;
      repeat (20) @(posedge clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge clk);
      // Reset values, and zero from unmapped places.
      for (int i = 0; i < 7; i++) begin
         xfer({1'b0, addr_tab[i]}, 8'h00);
         chk({8'h00, rd}, {8'h00, rst_tab[i]});
      end
      // Back-to-back writes with asymmetric patterns, then read back.
      for (int i = 0; i < 5; i++) xfer({1'b1, addr_tab[i]}, pat_tab[i]);
      for (int i = 0; i < 5; i++) begin
         xfer({1'b0, addr_tab[i]}, 8'h00);
         chk({8'h00, rd}, {8'h00, pat_tab[i]});
      end
      // Filter now off: the sample passes unchanged.
      current_sample = 16'sh1234;
      repeat (4) @(posedge clk);
      chk(filtered_current, 16'h1234);
      // Filter on: a constant sample is pure offset and must be removed.
      xfer({1'b1, `MHS_ADDR_FILTER}, 8'h01);
      repeat (4000) @(posedge clk);
      #1 chk(filtered_current, 16'h0000);
      // Masked event leaves the line released.
      xfer({1'b1, `MHS_ADDR_IRQ_MASK}, 8'h00);
      pulse(0);
      repeat (10) @(posedge clk);
      chk({14'h0000, irq_pending, link.irq_n_bus}, 16'h0001);
      xfer({1'b0, `MHS_ADDR_IRQ_STATUS}, 8'h00);
      // Each source alone: unmasked it pulls the line low, status shows it.
      for (int i = 0; i < 3; i++) begin
         xfer({1'b1, `MHS_ADDR_IRQ_MASK}, 8'h01 << i);
         if (i < 2) pulse(i);
         else repeat (WAVE_CYC + 10) @(posedge clk);
         repeat (10) @(posedge clk);
         chk({14'h0000, irq_pending, link.irq_n_bus}, 16'h0002);
         xfer({1'b0, `MHS_ADDR_IRQ_STATUS}, 8'h00);
         chk({8'h00, rd & (8'h01 << i)}, {8'h00, 8'h01 << i});
         repeat (10) @(posedge clk);
         if (i < 2) chk({15'h0000, irq_pending}, 16'h0000);
      end
      xfer({1'b1, `MHS_ADDR_IRQ_MASK}, 8'h00);
      // Calibration output follows the selected power only.
      xfer({1'b1, `MHS_ADDR_NUM}, 8'hFF);
      xfer({1'b1, `MHS_ADDR_DEN}, 8'h00);
      for (int m = 0; m < 4; m++) begin
         reactive_power = m[1] ? 16'h0000 : 16'hFFFF;
         apparent_power = m[1] ? 16'hFFFF : 16'h0000;
         xfer({1'b1, `MHS_ADDR_WAVEMODE}, {m[0], 7'h00});
         count_toggles();
         chk({14'h0000, n >= 190, n == 0}, (m[0] == m[1]) ? 16'h0002 : 16'h0001);
      end
      // A large denominator slows the output to at most one toggle here.
      xfer({1'b1, `MHS_ADDR_DEN}, 8'hFF);
      count_toggles();
      chk({15'h0000, n <= 1}, 16'h0001);
      end_sim();
   end
endmodule
